// File: logic/mtw_pkg.sv
package mtw_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and time base
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned MS_PERIOD_NS  = 1000000;
	// Longest time rounds down; result stays well above one cycle
	localparam int unsigned MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////
	// Operand widths and values
	localparam int unsigned ARG_W    = 32;
	localparam int unsigned OP_W     = 2;
	localparam logic        UNIT_MS  = 1'b0;
	localparam logic        UNIT_SMP = 1'b1;
	localparam logic [31:0] ZERO_32  = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////
	// Command codes from the sequencer
	localparam logic [1:0] OP_DIST  = 2'h0;
	localparam logic [1:0] OP_SPEED = 2'h1;
	localparam logic [1:0] OP_TIME  = 2'h2;

	// Wait states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_DIST,
		ST_SPEED,
		ST_TIME
	} mtw_state_t;

endpackage

// File: logic/mtw_time_if.sv
`timescale 1ns/100ps
// Time reference requests and elapsed counts
interface mtw_time_if;
	logic        set_ref;
	logic        adv_ref;
	logic        adv_unit;
	logic [31:0] adv_amt;
	logic [31:0] el_ms;
	logic [31:0] el_smp;

	modport timer (input set_ref, adv_ref, adv_unit, adv_amt, output el_ms, el_smp);
	modport user  (output set_ref, adv_ref, adv_unit, adv_amt, input el_ms, el_smp);
endinterface

// File: logic/mtw_time_base.sv
`timescale 1ns/100ps
module mtw_time_base #(
	parameter int unsigned MS_CYCLES = mtw_pkg::MS_CYCLES
) (
	// Clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_rst_n,
	// Servo sample strobe
	input  wire logic i_sample_tick,
	// Reference control
	mtw_time_if.timer tb
);

	logic [31:0] div_ff;
	logic [31:0] now_ms_ff;
	logic [31:0] now_smp_ff;
	logic [31:0] ref_ms_ff;
	logic [31:0] ref_smp_ff;
	wire         ms_wrap;

	////////////////////////////////////////////////////////////////////////
	// Millisecond divider
	assign ms_wrap = (div_ff == 32'(MS_CYCLES - 1));

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_ff    <= mtw_pkg::ZERO_32;
			now_ms_ff <= mtw_pkg::ZERO_32;
		end else begin
			div_ff    <= ms_wrap ? mtw_pkg::ZERO_32 : div_ff + 32'h1;
			now_ms_ff <= now_ms_ff + {31'h0, ms_wrap};
		end
	end

	// Sample counter, wraps freely; elapsed uses modular difference
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			now_smp_ff <= mtw_pkg::ZERO_32;
		else
			now_smp_ff <= now_smp_ff + {31'h0, i_sample_tick};
	end

	// Reference: set loads both units, advance moves the chosen one
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ref_ms_ff  <= mtw_pkg::ZERO_32;
			ref_smp_ff <= mtw_pkg::ZERO_32;
		end else if (tb.set_ref) begin
			ref_ms_ff  <= now_ms_ff;
			ref_smp_ff <= now_smp_ff;
		end else if (tb.adv_ref) begin
			if (tb.adv_unit == mtw_pkg::UNIT_SMP)
				ref_smp_ff <= ref_smp_ff + tb.adv_amt;
			else
				ref_ms_ff <= ref_ms_ff + tb.adv_amt;
		end
	end

	assign tb.el_ms  = now_ms_ff - ref_ms_ff;
	assign tb.el_smp = now_smp_ff - ref_smp_ff;

endmodule // mtw_time_base

// File: logic/mtw_trip_unit.sv
`timescale 1ns/100ps
// What this block does
// - Distance wait ends at signed offset from origin
// - Distance wait ends when profiling finishes
// - In jog, heading away ends distance wait
// - Distance operand is signed 32-bit counts
// - Stepper axis compares step buffer position
// - Tracking mode reversal reloads the origin
// - Chained distance waits measure from previous end
// - Speed wait ends when speed reaches setpoint
// - Unreached speed ends wait when diverging
// - Speed wait exact only for linear ramps
// - Time zero loads reference, releases at once
// - Positive time waits from reference, keeps it
// - Negative time waits then advances reference
// - Unit operand selects milliseconds or samples
// - Time operand signed 32-bit, default zero
module mtw_trip_unit #(
	parameter int unsigned MS_CYCLES = mtw_pkg::MS_CYCLES
) (
	// Clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	// Sequencer command
	input  wire logic        i_cmd_valid,
	input  wire logic [1:0]  i_cmd_op,
	input  wire logic [31:0] i_cmd_arg,
	input  wire logic        i_cmd_unit,
	output logic             o_busy,
	output logic             o_release,
	// Profiler and axis state
	input  wire logic        i_sample_tick,
	input  wire logic        i_prof_active,
	input  wire logic        i_move_start,
	input  wire logic        i_jog_mode,
	input  wire logic        i_track_mode,
	input  wire logic        i_stepper,
	input  wire logic [31:0] i_cmd_pos,
	input  wire logic [31:0] i_step_pos,
	input  wire logic [31:0] i_prof_speed,
	input  wire logic [31:0] i_speed_set
);

	// Absolute difference of two signed words, as unsigned
	function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
		logic signed [32:0] d;
		d = $signed({a[31], a}) - $signed({b[31], b});
		abs_diff = d[32] ? 32'(-d) : d[31:0];
	endfunction

	mtw_time_if tif ();

	mtw_pkg::mtw_state_t state_ff;
	mtw_pkg::mtw_state_t nxt_state;
	logic        busy_ff;
	logic        release_ff;
	logic        nxt_release;
	logic [31:0] origin_ff;
	logic [31:0] dist_ff;
	logic [31:0] mag_ff;
	logic        neg_ff;
	logic        unit_ff;
	logic [31:0] err_ff;
	logic        dir_ff;
	logic        moving_ff;

	////////////////////////////////////////////////////////////////////////
	// Command decode
	wire accept    = i_cmd_valid && !busy_ff;
	wire acc_dist  = accept && (i_cmd_op == mtw_pkg::OP_DIST);
	wire acc_speed = accept && (i_cmd_op == mtw_pkg::OP_SPEED);
	wire acc_time  = accept && (i_cmd_op == mtw_pkg::OP_TIME);
	wire time_zero = acc_time && (i_cmd_arg == mtw_pkg::ZERO_32);
	wire [31:0] arg_mag = i_cmd_arg[31] ? 32'(-i_cmd_arg) : i_cmd_arg;

	////////////////////////////////////////////////////////////////////////
	// Distance condition
	wire [31:0] pos_now    = i_stepper ? i_step_pos : i_cmd_pos;
	wire [31:0] target     = origin_ff + dist_ff;
	wire [31:0] remain     = target - pos_now;
	wire        dist_neg   = dist_ff[31];
	wire        spd_neg    = i_prof_speed[31];
	wire        spd_nz     = |i_prof_speed;
	// Wrap-safe only while the move stays inside half the count range
	wire        crossed    = dist_neg ? !remain[31] : (remain[31] || remain == 32'h0);
	wire        heads_away = i_jog_mode && spd_nz && (spd_neg != dist_neg);
	wire        dist_hit   = crossed || !i_prof_active || heads_away;
	wire        reversal   = i_track_mode && spd_nz && moving_ff && (spd_neg != dir_ff);

	////////////////////////////////////////////////////////////////////////
	// Speed and time conditions
	wire [31:0] spd_err  = abs_diff(i_speed_set, i_prof_speed);
	// Smoothed ramps may jump past the setpoint; divergence catches it late
	wire        spd_hit  = (spd_err == 32'h0) || (spd_err > err_ff);
	wire [31:0] el_sel   = (unit_ff == mtw_pkg::UNIT_SMP) ? tif.el_smp : tif.el_ms;
	wire        time_hit = (el_sel >= mag_ff);

	wire in_dist  = (state_ff == mtw_pkg::ST_DIST);
	wire in_speed = (state_ff == mtw_pkg::ST_SPEED);
	wire in_time  = (state_ff == mtw_pkg::ST_TIME);
	wire dist_done = in_dist && i_sample_tick && dist_hit;
	wire time_done = in_time && i_sample_tick && time_hit;

	// Time reference requests
	assign tif.set_ref  = time_zero;
	assign tif.adv_ref  = time_done && neg_ff;
	assign tif.adv_unit = unit_ff;
	assign tif.adv_amt  = mag_ff;

	mtw_time_base #(
		.MS_CYCLES (MS_CYCLES)
	) u_time (
		.i_ref_clk     (i_ref_clk),
		.i_rst_n       (i_rst_n),
		.i_sample_tick (i_sample_tick),
		.tb            (tif.timer)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state; conditions only looked at on sample strobes
	always_comb begin
		nxt_state   = state_ff;
		nxt_release = 1'b0;
		case (state_ff)
			mtw_pkg::ST_IDLE: begin
				if (time_zero)
					nxt_release = 1'b1;
				else if (acc_dist)
					nxt_state = mtw_pkg::ST_DIST;
				else if (acc_speed)
					nxt_state = mtw_pkg::ST_SPEED;
				else if (acc_time)
					nxt_state = mtw_pkg::ST_TIME;
			end
			mtw_pkg::ST_DIST,
			mtw_pkg::ST_SPEED,
			mtw_pkg::ST_TIME: begin
				if (dist_done || time_done || (in_speed && i_sample_tick && spd_hit)) begin
					nxt_state   = mtw_pkg::ST_IDLE;
					nxt_release = 1'b1;
				end
			end
			default: nxt_state = mtw_pkg::ST_IDLE;
		endcase
	end

	// Control flops
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_ff   <= mtw_pkg::ST_IDLE;
			busy_ff    <= 1'b0;
			release_ff <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			busy_ff    <= (nxt_state != mtw_pkg::ST_IDLE);
			release_ff <= nxt_release;
		end
	end

	// Operand capture
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dist_ff <= mtw_pkg::ZERO_32;
			mag_ff  <= mtw_pkg::ZERO_32;
			neg_ff  <= 1'b0;
			unit_ff <= mtw_pkg::UNIT_MS;
		end else if (accept) begin
			dist_ff <= i_cmd_arg;
			mag_ff  <= arg_mag;
			neg_ff  <= i_cmd_arg[31];
			unit_ff <= i_cmd_unit;
		end
	end

	// Speed error history for divergence; seeded at acceptance
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			err_ff <= mtw_pkg::ZERO_32;
		else if (acc_speed || (in_speed && i_sample_tick))
			err_ff <= spd_err;
	end

	// Distance origin: move start, chained end point, or reversal
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			origin_ff <= mtw_pkg::ZERO_32;
		else if (i_move_start)
			origin_ff <= pos_now;
		else if (dist_done)
			origin_ff <= target;
		else if (i_sample_tick && reversal)
			origin_ff <= pos_now;
	end

	// Last nonzero direction of travel
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dir_ff    <= 1'b0;
			moving_ff <= 1'b0;
		end else if (i_sample_tick && spd_nz) begin
			dir_ff    <= spd_neg;
			moving_ff <= 1'b1;
		end
	end

	assign o_busy    = busy_ff;
	assign o_release = release_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	sequence dist_tick_s;
		in_dist && i_sample_tick;
	endsequence

	sequence released_s;
		o_release && !o_busy;
	endsequence

	dist_cross_a: assert property (dist_tick_s ##0 crossed |=> released_s)
		else $error("distance crossing did not release");
	prof_done_a: assert property (dist_tick_s ##0 !i_prof_active |=> released_s)
		else $error("profile end did not release");
	jog_away_a: assert property (dist_tick_s ##0 heads_away |=> released_s)
		else $error("jog reversal away did not release");
	// Step buffer short of the target must hold the wait even if servo position passed it
	step_src_a: assert property (dist_tick_s ##0 (i_stepper && i_prof_active
		&& !heads_away && (dist_neg ? ($signed(target - i_step_pos) < 0)
		: ($signed(target - i_step_pos) > 0))) |=> !o_release)
		else $error("stepper position ignored");
	track_reload_a: assert property (i_sample_tick && reversal && !i_move_start
		&& !dist_done |=> origin_ff == $past(pos_now))
		else $error("reversal did not reload origin");
	chain_origin_a: assert property (dist_done && !i_move_start
		|=> origin_ff == $past(target) && o_release)
		else $error("chained origin wrong");
	speed_hit_a: assert property (in_speed && i_sample_tick && spd_hit
		|=> released_s)
		else $error("speed wait did not release");
	time_zero_a: assert property (time_zero |=> released_s ##1 tif.el_ms <= 32'h1)
		else $error("zero time wait wrong");
	time_pos_a: assert property (time_done && !neg_ff
		|=> $stable(u_time.ref_ms_ff) && $stable(u_time.ref_smp_ff) && o_release)
		else $error("positive time wait moved reference");
	// Advance lands on the unit the wait counted in, either unit
	time_neg_a: assert property (time_done && neg_ff
		|=> (($past(unit_ff) == mtw_pkg::UNIT_SMP)
		? (u_time.ref_smp_ff == $past(u_time.ref_smp_ff) + $past(mag_ff))
		: (u_time.ref_ms_ff == $past(u_time.ref_ms_ff) + $past(mag_ff))))
		else $error("negative time wait did not advance reference");
	no_tick_a: assert property (busy_ff && !i_sample_tick |=> !o_release)
		else $error("release outside a sample");

endmodule // mtw_trip_unit

// File: verif/mtw_prof_model.sv
`timescale 1ns/100ps
// Profiler stand-in: sample strobe, linear speed ramp, position, step buffer
module mtw_prof_model #(
	parameter int SMP = 4
) (
	// Clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	// Speed change per sample
	input  wire logic [31:0] i_accel,
	// Profiler state
	output logic             o_tick,
	output logic [31:0]      o_pos,
	output logic [31:0]      o_step_pos,
	output logic [31:0]      o_speed
);
	int cnt_ff;

	////////////////////////////////////////////////////////////////////////
	// Ramp is linear only; step buffer trails by one sample
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_ff     <= 0;
			o_tick     <= 1'b0;
			o_pos      <= 32'h0000_0000;
			o_step_pos <= 32'h0000_0000;
			o_speed    <= 32'h0000_0000;
		end else begin
			cnt_ff <= (cnt_ff == SMP - 1) ? 0 : cnt_ff + 1;
			o_tick <= (cnt_ff == SMP - 1);
			if (o_tick) begin
				o_speed    <= o_speed + i_accel;
				o_pos      <= o_pos + o_speed + i_accel;
				o_step_pos <= o_pos;
			end
		end
	end
endmodule // mtw_prof_model

// File: verif/test_motion_trippoint_wait_unit.sv
`timescale 1ns/100ps
module test_motion_trippoint_wait_unit;
	localparam int MSC = 10;
	logic        clk, rst_n, valid, unit, busy, rel, tick;
	logic        active, mstart, jog, track, stepr;
	logic [1:0]  op;
	logic [31:0] arg, pos, spos, spd, sset, acc;
	int          num_errors = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          tk = 0;
	int          k, c0, p1, s1, org, ref_t, e, a;

	mtw_trip_unit #(.MS_CYCLES(MSC)) u_mtw_trip_unit (
		.i_ref_clk(clk), .i_rst_n(rst_n), .i_cmd_valid(valid), .i_cmd_op(op),
		.i_cmd_arg(arg), .i_cmd_unit(unit), .o_busy(busy), .o_release(rel),
		.i_sample_tick(tick), .i_prof_active(active), .i_move_start(mstart),
		.i_jog_mode(jog), .i_track_mode(track), .i_stepper(stepr), .i_cmd_pos(pos),
		.i_step_pos(spos), .i_prof_speed(spd), .i_speed_set(sset));
	mtw_prof_model #(.SMP(4)) u_mtw_prof_model (
		.i_ref_clk(clk), .i_rst_n(rst_n), .i_accel(acc), .o_tick(tick),
		.o_pos(pos), .o_step_pos(spos), .o_speed(spd));

	////////////////////////////////////////////////////////////////////////
	// Clock, then cycle and sample counts; a hang ends at the ceiling
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (tick === 1'b1) tk <= tk + 1;
		if (cyc == 8000) begin
			num_errors = num_errors + 1;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reference model: ticks until a distance or speed wait lets go
	function automatic int dist_ticks(int o, int p, int s, int ac, int d, bit jg, bit tr, bit act);
		int last;
		last = s > 0 ? 1 : (s < 0 ? -1 : 0);
		for (int n = 1; n < 300; n++) begin
			if (tr && s != 0 && last != 0 && (s > 0 ? 1 : -1) != last) o = p;
			if (s != 0) last = s > 0 ? 1 : -1;
			if (!act || (d >= 0 ? p >= o + d : p <= o + d)) return n;
			if (jg && s != 0 && ((s < 0) != (d < 0))) return n;
			s = s + ac;
			p = p + s;
		end
		return 0;
	endfunction
	function automatic int spd_ticks(int s, int ac, int t);
		int dp;
		int d;
		dp = t > s ? t - s : s - t;
		for (int n = 1; n < 300; n++) begin
			d = t > s ? t - s : s - t;
			if (d == 0 || d > dp) return n;
			dp = d;
			s = s + ac;
		end
		return 0;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Compare, verdict, and one command from issue to release
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] expv);
		num_checks = num_checks + 1;
		if (seen !== expv) begin
			num_errors = num_errors + 1;
			$display("[FAIL] %s expected %0d seen %0d", nm, expv, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Issued just after a sample so the first evaluated sample is known
	task automatic run(input logic [1:0] o, input int v, input logic u, input bit ms, input bit act);
		@(negedge clk);
		while (tick !== 1'b1) @(negedge clk);
		@(posedge clk);
		mstart <= ms;
		@(posedge clk);
		mstart <= 1'b0;
		valid <= 1'b1;
		op <= o;
		arg <= v;
		unit <= u;
		@(negedge clk);
		p1 = stepr ? int'(spos) : int'(pos);
		s1 = int'(spd);
		if (ms) org = p1;
		c0 = cyc;
		@(posedge clk);
		valid <= 1'b0;
		active <= act;
		k = 0;
		for (int i = 0; i < 3000 && rel !== 1'b1; i++) begin
			@(negedge clk);
			if (tick === 1'b1 && busy === 1'b1) k++;
		end
		chk("release", {31'h0, rel}, 32'h1);
	endtask
	task automatic tw(input int n);
		run(mtw_pkg::OP_TIME, n, 1'b1, 1'b0, 1'b1);
		e = tk - ref_t - (n < 0 ? -n : n);
		chk("sample wait", 32'(e >= 0 && e <= 1), 32'h1);
		if (n < 0) ref_t = ref_t - n;
	endtask
	task automatic dw(input int d, input bit ms, input bit jg, input bit tr, input bit act);
		run(mtw_pkg::OP_DIST, d, 1'b0, ms, act);
		chk("distance", k, dist_ticks(org, p1, s1, int'(acc), d, jg, tr, act));
		org = org + d;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{valid, unit, mstart, jog, track, stepr, rst_n} = 7'h00;
		active = 1'b1;
		op = 2'h0;
		{arg, sset, acc} = 96'h0;
		void'($urandom(32'h361566dd));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("idle", {30'h0, busy, rel}, 32'h0);
		// Zero wait answers next cycle; sample waits chain off its reference
		run(mtw_pkg::OP_TIME, 0, 1'b1, 1'b0, 1'b1);
		chk("zero wait", cyc - c0, 32'h1);
		ref_t = tk;
		tw(3 + int'($urandom % 4));
		tw(-(12 + int'($urandom % 4)));
		tw(3 + int'($urandom % 4));
		// Millisecond unit is slower than samples with these settings
		run(mtw_pkg::OP_TIME, 0, 1'b0, 1'b0, 1'b1);
		e = c0;
		run(mtw_pkg::OP_TIME, 3, 1'b0, 1'b0, 1'b1);
		e = cyc - e;
		chk("ms wait", 32'(e >= 2 * MSC && e <= 3 * MSC + 8), 32'h1);
		// Speed reached while ramping up, then missed while ramping down
		a = 3 + int'($urandom % 5);
		@(posedge clk);
		acc <= a;
		sset <= 6 * a;
		run(mtw_pkg::OP_SPEED, 0, 1'b0, 1'b0, 1'b1);
		chk("speed up", k, spd_ticks(s1, a, 6 * a));
		@(posedge clk);
		sset <= spd - 3 * a - 1;
		acc <= -a;
		run(mtw_pkg::OP_SPEED, 0, 1'b0, 1'b0, 1'b1);
		chk("speed miss", k, spd_ticks(s1, -a, int'(sset)));
		// Chained distances, last one on the step buffer; no follower axis
		@(posedge clk);
		acc <= 32'h0000_0000;
		dw(30 + int'($urandom % 40), 1'b1, 1'b0, 1'b0, 1'b1);
		dw(30 + int'($urandom % 40), 1'b0, 1'b0, 1'b0, 1'b1);
		@(posedge clk);
		stepr <= 1'b1;
		dw(30 + int'($urandom % 40), 1'b0, 1'b0, 1'b0, 1'b1);
		// Reversal under tracking moves the start point
		@(posedge clk);
		stepr <= 1'b0;
		track <= 1'b1;
		acc <= -32'sd4;
		dw(-12, 1'b1, 1'b0, 1'b1, 1'b1);
		// Jog heading away, then profiler finishing mid-wait
		@(posedge clk);
		acc <= 32'h0000_0000;
		track <= 1'b0;
		jog <= 1'b1;
		dw(1000, 1'b1, 1'b1, 1'b0, 1'b1);
		@(posedge clk);
		jog <= 1'b0;
		dw(1000, 1'b1, 1'b0, 1'b0, 1'b0);
		@(posedge clk);
		active <= 1'b1;
		print_verdict();
	end
endmodule // test_motion_trippoint_wait_unit
